// ==== core/ssc_consts.vh ====
// Purpose: Constants for the synchronous serial clock and FIFO front end
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define SSC_OFF_CTRL0     12'h000
`define SSC_OFF_CTRL1     12'h004
`define SSC_OFF_DATA      12'h008
`define SSC_OFF_STATUS    12'h00c
`define SSC_OFF_PRESCALE  12'h010
`define SSC_OFF_IDENT     12'h014

// ****************************************
// Field positions
// ****************************************
`define SSC_CR0_DSS_LSB   0
`define SSC_CR0_DSS_MSB   3
`define SSC_CR0_SCR_LSB   8
`define SSC_CR0_SCR_MSB   15
`define SSC_CR1_LBM       0
`define SSC_CR1_ENABLE    1
`define SSC_CR1_SLAVE     2

// ****************************************
// Reset values and limits
// ****************************************
`define SSC_CR0_RESET     16'h0000
`define SSC_CR1_RESET     3'h0
`define SSC_CPS_RESET     8'h02
`define SSC_CPS_MIN       8'h02
`define SSC_DSS_MIN       4'h3
`define SSC_IDENT_VALUE   32'h00005a5a // Arbitrary value
`define SSC_SYSCLK_MHZ    50
`define SSC_SLAVE_RATIO   12

`endif

// ==== core/ssc_fifo.v ====
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes:   A push while full is ignored; caller must honour full
module ssc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign level     = count;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ssc_fifo

// ==== core/ssc_sync.v ====
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to pclk
// Notes:   First stage is read only by the second
module ssc_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire pclk,
  input  wire presetn,
  input  wire d,
  output reg  q
);
  reg meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ssc_sync

// ==== core/ssc_top.v ====
// Purpose: Serial port front end: bit clock divider, FIFOs, shifter, APB slave
// Assumes: pclk is the system clock; pins pass two flip-flops
// Notes:   Mode 0 style framing (idle clock low, sample on rising edge)
//          Slave frames follow the synchronised select and bit clock pins
//          Drive enables are low while a pin is driven
// Contract
// - Port works as master or as slave, chosen by a control bit.
// - Transmit FIFO is 16 bits wide and 8 entries deep.
// - Receive FIFO is separate, 16 bits wide and 8 entries deep.
// - Frame length is programmable from 4 to 16 bits.
// - Loopback mode returns transmitted data into the receive path.
// - First divider stage divides by an even prescale from 2 to 254.
// - Second stage divides by one plus serial clock rate, 1 to 256.
// - Bit clock equals system clock over prescale times one plus rate.
// - Data register write pushes the word into the transmit FIFO.
// - Data register read pops the oldest word from the receive FIFO.
// - Transmit FIFO words are serialised on the transmit line.
// - Received bits gather in a shifter, then load whole into receive FIFO.
// - Divider chain runs from the 50 MHz system clock.
// - Frames are shifted most significant bit first.
// - Bit clock idles inactive, toggles only during a transfer.
`include "ssc_consts.vh"
module ssc_top #(
  parameter DATA_W = 16,
  parameter DEPTH  = 8,
  parameter AW     = 3
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         serial_bit_clock_out,
  output reg         serial_bit_clock_oen_n,
  input  wire        serial_bit_clock_in,
  output reg         frame_sel_out_n,
  output reg         frame_sel_oen_n,
  input  wire        frame_sel_in_n,
  output reg         serial_tx_line,
  output reg         serial_tx_oen_n,
  input  wire        serial_rx_line
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE  = 3'b100;

  // ****************************************
  // Registers and APB decode
  // ****************************************
  reg  [15:0]       ctrl0;
  reg  [2:0]        ctrl1;
  reg  [7:0]        prescale_divisor;
  wire [3:0]        frame_bits_m1  = ctrl0[`SSC_CR0_DSS_MSB:`SSC_CR0_DSS_LSB];
  wire [7:0]        serial_clock_rate = ctrl0[`SSC_CR0_SCR_MSB:`SSC_CR0_SCR_LSB];
  wire              loopback  = ctrl1[`SSC_CR1_LBM];
  wire              enable    = ctrl1[`SSC_CR1_ENABLE];
  wire              slave     = ctrl1[`SSC_CR1_SLAVE];
  wire              access    = psel & penable;
  wire              wr_access = access & pwrite;
  wire              rd_access = access & ~pwrite;
  wire              hit_data  = (paddr == `SSC_OFF_DATA);
  reg               addr_ok;
  wire              tx_in_ready;
  wire              rx_out_valid;
  wire [DATA_W-1:0] rx_out_data;
  wire [AW:0]       tx_level;
  wire [AW:0]       rx_level;
  wire              tx_out_valid;
  wire [DATA_W-1:0] tx_out_data;
  reg               tx_pop;
  reg               rx_push;
  reg  [DATA_W-1:0] rx_word;
  wire              rx_in_ready;
  reg               busy;

  // Zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok;

  // Six word registers, anything else is unmapped
  always @* begin
    case (paddr)
      `SSC_OFF_CTRL0, `SSC_OFF_CTRL1, `SSC_OFF_DATA, `SSC_OFF_STATUS,
      `SSC_OFF_PRESCALE, `SSC_OFF_IDENT: addr_ok = 1'b1;
      default:                            addr_ok = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0            <= `SSC_CR0_RESET;
      ctrl1            <= `SSC_CR1_RESET;
      prescale_divisor <= `SSC_CPS_RESET;
    end else if (wr_access) begin
      case (paddr)
        `SSC_OFF_CTRL0: begin
          ctrl0 <= pwdata[15:0];
          // Frame sizes below four bits become four
          if (pwdata[3:0] < `SSC_DSS_MIN) begin
            ctrl0[3:0] <= `SSC_DSS_MIN;
          end
        end
        `SSC_OFF_CTRL1: ctrl1 <= pwdata[2:0];
        `SSC_OFF_PRESCALE: begin
          // Bit 0 forced low, zero clamped to two
          prescale_divisor <= (pwdata[7:1] == 7'h00) ? `SSC_CPS_MIN
                                                     : {pwdata[7:1], 1'b0};
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  wire        tx_empty    = (tx_level == {(AW+1){1'b0}});
  wire [31:0] status_word = {20'h00000, rx_level, tx_level, busy, rx_out_valid,
                             tx_in_ready, tx_empty};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSC_OFF_CTRL0:    prdata <= {16'h0000, ctrl0};
        `SSC_OFF_CTRL1:    prdata <= {29'h00000000, ctrl1};
        // Empty data read keeps the last value
        `SSC_OFF_DATA:     prdata <= rx_out_valid ? {16'h0000, rx_out_data}
                                                  : prdata;
        `SSC_OFF_STATUS:   prdata <= status_word;
        `SSC_OFF_PRESCALE: prdata <= {24'h000000, prescale_divisor};
        `SSC_OFF_IDENT:    prdata <= `SSC_IDENT_VALUE; // Arbitrary value
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Data read bookkeeping
  // ****************************************
  // Pop only a word that was latched in the setup cycle
  reg rd_took;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_took <= 1'b0;
    end else if (psel && !penable) begin
      rd_took <= ~pwrite & hit_data & rx_out_valid;
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  ssc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_access & hit_data),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[DATA_W-1:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data),
    .level     (tx_level)
  );

  ssc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rd_access & hit_data & rd_took),
    .out_data  (rx_out_data),
    .level     (rx_level)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire sck_in_s;
  wire fss_in_s_n;
  wire rx_in_s;
  reg  sck_prev;

  ssc_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (serial_bit_clock_in),
    .q       (sck_in_s)
  );
  ssc_sync #(.RESET_VAL(1'b1)) u_sync_fss (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (frame_sel_in_n),
    .q       (fss_in_s_n)
  );
  ssc_sync #(.RESET_VAL(1'b0)) u_sync_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (serial_rx_line),
    .q       (rx_in_s)
  );

  // ****************************************
  // Two-stage bit clock divider
  // ****************************************
  // Counters rest at zero while idle, so a frame opens on a full half period
  reg  [7:0] pre_cnt;
  reg  [7:0] rate_cnt;
  wire       pre_tick  = (pre_cnt == prescale_divisor[7:1] - 8'h01);
  wire       half_tick = pre_tick & (rate_cnt == serial_clock_rate);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt  <= 8'h00;
      rate_cnt <= 8'h00;
    end else if (!busy || slave) begin
      pre_cnt  <= 8'h00;
      rate_cnt <= 8'h00;
    end else if (pre_tick) begin
      pre_cnt  <= 8'h00;
      rate_cnt <= (rate_cnt == serial_clock_rate) ? 8'h00 : rate_cnt + 8'h01;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  // Slave edges come from the synchronised pin, master edges from the divider
  reg  [2:0]        state;
  reg  [DATA_W-1:0] tx_shift;
  reg  [DATA_W-1:0] rx_shift;
  reg  [4:0]        bit_cnt;
  wire              slave_sel = slave & ~fss_in_s_n;
  wire              rise_ev   = slave ? (sck_in_s & ~sck_prev)
                                      : (half_tick & ~serial_bit_clock_out);
  wire              fall_ev   = slave ? (~sck_in_s & sck_prev)
                                      : (half_tick & serial_bit_clock_out);
  wire              rx_bit    = loopback ? serial_tx_line : rx_in_s;
  wire [4:0]        last_bit  = {1'b0, frame_bits_m1};
  wire [DATA_W-1:0] tx_aligned = tx_out_data << (4'hf - frame_bits_m1);

  always @* begin
    busy = (state != ST_IDLE);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_IDLE;
      tx_shift               <= {DATA_W{1'b0}};
      rx_shift               <= {DATA_W{1'b0}};
      bit_cnt                <= 5'h00;
      tx_pop                 <= 1'b0;
      rx_push                <= 1'b0;
      rx_word                <= {DATA_W{1'b0}};
      sck_prev               <= 1'b0;
      serial_bit_clock_out   <= 1'b0;
      serial_bit_clock_oen_n <= 1'b1;
      frame_sel_out_n        <= 1'b1;
      frame_sel_oen_n        <= 1'b1;
      serial_tx_line         <= 1'b0;
      serial_tx_oen_n        <= 1'b1;
    end else begin
      tx_pop                 <= 1'b0;
      rx_push                <= 1'b0;
      sck_prev               <= sck_in_s;
      // Drive enables follow the mode bits one cycle late
      serial_bit_clock_oen_n <= ~(enable & ~slave & ~loopback);
      frame_sel_oen_n        <= ~(enable & ~slave & ~loopback);
      serial_tx_oen_n        <= ~(enable & ~loopback & (~slave | slave_sel));
      case (state)
        ST_IDLE: begin
          serial_bit_clock_out <= 1'b0;
          frame_sel_out_n      <= 1'b1;
          // Slave may need to answer with zeros if nothing is queued
          if (enable && !tx_pop && rx_in_ready &&
              ((!slave && tx_out_valid) || slave_sel)) begin
            tx_pop          <= tx_out_valid;
            tx_shift        <= tx_out_valid ? tx_aligned : {DATA_W{1'b0}};
            serial_tx_line  <= tx_out_valid ? tx_aligned[DATA_W-1] : 1'b0;
            bit_cnt         <= 5'h00;
            frame_sel_out_n <= slave;
            state           <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!slave) begin
            if (half_tick) begin
              serial_bit_clock_out <= ~serial_bit_clock_out;
            end
          end
          if (rise_ev) begin
            rx_shift <= {rx_shift[DATA_W-2:0], rx_bit};
            if (bit_cnt == last_bit) begin
              state <= ST_DONE;
            end
          end
          if (fall_ev) begin
            tx_shift       <= {tx_shift[DATA_W-2:0], 1'b0};
            serial_tx_line <= tx_shift[DATA_W-2];
            bit_cnt        <= bit_cnt + 5'h01;
          end
          if (slave && fss_in_s_n) begin
            state <= ST_IDLE;
          end
        end
        ST_DONE: begin
          // Whole word loaded, upper bits masked to zero
          rx_word <= rx_shift & ~({DATA_W{1'b1}} << (last_bit + 5'h01));
          rx_push <= 1'b1;
          if (!slave && half_tick) begin
            serial_bit_clock_out <= 1'b0;
          end
          if (slave || !serial_bit_clock_out || half_tick) begin
            frame_sel_out_n <= 1'b1;
            state           <= ST_IDLE;
          end else begin
            rx_push <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // ssc_top

// ==== dv/ssc_props.sv ====
// Purpose: Checker for the serial port front end
// Assumes: Bound to ssc_top, one clock domain
// Notes:   Tracks control writes to know frame length and modes
module ssc_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        serial_bit_clock_out,
  input wire        serial_bit_clock_oen_n,
  input wire        frame_sel_out_n,
  input wire        frame_sel_oen_n,
  input wire        serial_tx_line,
  input wire        serial_tx_oen_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] c0;
  logic [2:0]  c1;
  logic [4:0]  nr;
  logic        sck_q;
  wire         wr   = psel && penable && pwrite;
  wire  [4:0]  flen = (c0[3:0] < 4'h3) ? 5'h4 : {1'b0, c0[3:0]} + 5'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Shadow of control writes, bit clock rises per frame
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0    <= 16'h0000;
      c1    <= 3'h0;
      nr    <= 5'h00;
      sck_q <= 1'b0;
    end else begin
      if (wr && paddr == 12'h000) c0 <= pwdata[15:0];
      if (wr && paddr == 12'h004) c1 <= pwdata[2:0];
      nr    <= frame_sel_out_n ? 5'h00 : nr + {4'h0, serial_bit_clock_out & ~sck_q};
      sck_q <= serial_bit_clock_out;
    end
  end
  sequence frame_done;
    $rose(frame_sel_out_n);
  endsequence
  frame_len_a: assert property (frame_done |-> nr == flen)
    else $error("frame bit count wrong");
  clk_idle_a: assert property (frame_sel_out_n |-> !serial_bit_clock_out)
    else $error("bit clock active outside frame");
  tx_hold_a: assert property ($rose(serial_bit_clock_out) |-> $stable(serial_tx_line))
    else $error("tx changed at sampling edge");
  lb_quiet_a: assert property (c1[0] && $past(c1[0]) |->
    serial_tx_oen_n && serial_bit_clock_oen_n && frame_sel_oen_n)
    else $error("pins driven in loopback");
  slave_quiet_a: assert property (c1[2] && $past(c1[2]) |->
    serial_bit_clock_oen_n && frame_sel_oen_n)
    else $error("slave drives clock or select");
  ready_on_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("unmapped access without error");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside read setup");
endmodule // ssc_props

bind ssc_top ssc_props ssc_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .serial_bit_clock_out, .serial_bit_clock_oen_n,
  .frame_sel_out_n, .frame_sel_oen_n, .serial_tx_line, .serial_tx_oen_n);

// ==== dv/ssc_peer.sv ====
// Purpose: Slave device model on the far side of the serial pins
// Assumes: Idle-low clock, capture on rising edge, MSB first
// Notes:   On release its data line goes to the inverse of its last bit
module ssc_peer (
  input  wire         sclk,
  input  wire         sel_n,
  input  wire         mosi,
  input  wire  [15:0] reply,
  input  wire  [4:0]  nbits,
  output logic        miso,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx;
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    idx = int'(nbits) - 1;
    got = 16'h0000;
    miso = reply[idx];
  end
  always @(negedge sclk) if (!sel_n && idx > 0) begin
    idx--;
    miso = reply[idx];
  end
  always @(posedge sclk) if (!sel_n) got = {got[14:0], mosi};
  always @(posedge sel_n) miso = ~miso;
endmodule // ssc_peer

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the serial port front end
// Assumes: Peer model as slave, loopback for FIFO depth
// Notes:   Slave inputs fed from resolved wire levels
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, slv, sck_d, ext_sck, ext_fs_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, sck, sck_oen_n, fs_n, fs_oen_n, txd, tx_oen_n, rxd;
  logic [15:0] reply, wd, q[$];
  wire  [15:0] got;
  logic [4:0]  nb;
  int          n_errors, num_checks, ps, rt, cnt, lastr, per;
  wire         sck_w = sck_oen_n ? ext_sck : sck;
  wire         fs_w  = fs_oen_n ? ext_fs_n : fs_n;
  wire         tx_w  = tx_oen_n ? 1'b0 : txd;
  always #5 pclk = ~pclk;
  ssc_top ssc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_bit_clock_out(sck), .serial_bit_clock_oen_n(sck_oen_n),
    .serial_bit_clock_in(sck_w), .frame_sel_out_n(fs_n), .frame_sel_oen_n(fs_oen_n),
    .frame_sel_in_n(fs_w), .serial_tx_line(txd), .serial_tx_oen_n(tx_oen_n),
    .serial_rx_line(rxd));
  ssc_peer ssc_peer_inst (.sclk(sck_w), .sel_n(fs_w), .mosi(tx_w), .reply, .nbits(nb),
    .miso(rxd), .got);
  // Bit clock period in pclk cycles
  always @(posedge pclk) begin
    cnt++;
    if (sck_w && !sck_d && !fs_w) begin
      per = cnt - lastr;
      lastr = cnt;
    end
    sck_d = sck_w;
  end
  function automatic logic [15:0] msk(input logic [4:0] n);
    return 16'hffff >> (5'h10 - n);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      i++;
    end while (rd[3:0] !== 4'b0111 && i < 500);
    if (rd[3:0] !== 4'b0111) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, sck_d} = 6'h00;
    {paddr, pwdata, reply, nb} = '0;
    {cnt, lastr, per} = '0;
    {ext_sck, ext_fs_n} = 2'b01;
    void'($urandom(32'habbb57c3));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("prescale reset", 32'h2, rd)
    apb(1'b1, 12'h010, 32'hff);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("prescale max", 32'hfe, rd)
    apb(1'b1, 12'h018, 32'h1);
    `CHK("unmapped error", 1'b1, slv)
    apb(1'b1, 12'h004, 32'h6);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("ctrl1", 32'h6, rd)
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h000, 32'hf);
    apb(1'b1, 12'h010, 32'h2);
    repeat (9) begin
      wd = 16'($urandom);
      if (q.size() < 8) q.push_back(wd);
      apb(1'b1, 12'h008, {16'h0000, wd});
    end
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("tx full status", 8'h80, rd[7:0])
    apb(1'b1, 12'h004, 32'h3);
    wait_done;
    `CHK("rx level", 4'h8, rd[11:8])
    while (q.size() > 0) begin
      wd = q.pop_front();
      apb(1'b0, 12'h008, 32'h0);
      `CHK("loop word", wd, rd[15:0])
    end
    apb(1'b0, 12'h008, 32'h0);
    `CHK("empty read", {16'h0000, wd}, rd)
    apb(1'b1, 12'h004, 32'h2);
    for (int i = 0; i < 6; i++) begin
      nb = (i == 0) ? 5'h4 : (i == 1) ? 5'h10 : 5'($urandom_range(16, 4));
      ps = 2 * $urandom_range(4, 2);
      rt = $urandom_range(3, 1);
      reply = 16'($urandom) & msk(nb);
      wd = 16'($urandom);
      apb(1'b1, 12'h000, {16'h0000, 8'(rt), 4'h0, 4'(nb - 5'h1)});
      apb(1'b1, 12'h010, 32'(ps));
      apb(1'b1, 12'h008, {16'h0000, wd});
      wait_done;
      apb(1'b0, 12'h008, 32'h0);
      `CHK("tx bits", wd & msk(nb), got)
      `CHK("rx word", {16'h0000, reply}, rd)
      `CHK("bit period", ps * (rt + 1), per)
    end
    // Slave: bench clocks the link at one twelfth of pclk
    apb(1'b1, 12'h004, 32'h6);
    for (int k = 0; k < 2; k++) begin
      nb = (k == 0) ? 5'h10 : 5'($urandom_range(16, 4));
      reply = 16'($urandom) & msk(nb);
      wd = 16'($urandom);
      apb(1'b1, 12'h000, {16'h0000, 8'h00, 4'h0, 4'(nb - 5'h1)});
      apb(1'b1, 12'h008, {16'h0000, wd});
      ext_fs_n <= 1'b0;
      repeat (6) @(posedge pclk);
      repeat (nb) begin
        ext_sck <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_sck <= 1'b0;
        repeat (6) @(posedge pclk);
      end
      ext_fs_n <= 1'b1;
      wait_done;
      apb(1'b0, 12'h008, 32'h0);
      `CHK("slave tx bits", wd & msk(nb), got)
      `CHK("slave rx word", {16'h0000, reply}, rd)
    end
    report_and_stop;
  end
endmodule // tb_top
